// ==== rtl/psd_cfg.svh ====
// Purpose: constants of the position sensor safety diagnostics block
// Assumes: one 50 MHz clock, settings delivered as plain ports
// Notes: included by bare name
`ifndef PSD_CFG_SVH
`define PSD_CFG_SVH

// error flag register bit positions
`define PSD_FL_GAIN      0
`define PSD_FL_HALF      1
`define PSD_FL_ECC_SGL   2
`define PSD_FL_ECC_DBL   3
`define PSD_FL_BROKEN    4
`define PSD_FL_OFFSET    5
`define PSD_FL_CORDIC    6
`define PSD_FL_RESET     8'h00

// protected settings byte layout
`define PSD_SET_OFFSET_EN 0
`define PSD_SET_HALF_EN   1
`define PSD_SET_GAIN_EN   2
`define PSD_SET_BROKEN_EN 3
`define PSD_SET_THR_LSB   4
`define PSD_SET_RESET     8'h00

// protection register layout
`define PSD_PROT_EN_BIT   7
`define PSD_CHSUM_RESET   7'h00

// broken chain threshold step is 256 lsb, an 8-bit shift
`define PSD_THR_SHIFT     8
// magnitude setpoint held by the gain loop
`define PSD_MAG_TARGET    14'h1000

// safe-state output levels
`define PSD_COMM_SAFE     3'h0
`define PSD_INCR_SAFE     3'h7
`define PSD_OUT_RESET     3'h0

`endif

// ==== rtl/psd_pkg.sv ====
// Purpose: types of the position sensor safety diagnostics block
// Assumes: nothing beyond the header constants
// Notes: no imports; used as psd_pkg::name
package psd_pkg;
	typedef logic [7:0]  psd_flags_t;
	typedef logic [8:0]  psd_prot_data_t;
	typedef logic [12:0] psd_codeword_t;
	typedef logic [4:0]  psd_check_t;
endpackage

// ==== rtl/psd_diag.sv ====
// Purpose: diagnostics, safe-state forcing, sticky flags and settings protection
// Assumes: fault inputs synchronous to clk_i; read strobe one cycle wide
// Notes: settings and enable protected by a secded code over 9 bits
//
// Contract
// - present the automatic gain value as a readable output field.
// - gain loop at its limit sets the gain-limit warning bit.
// - magnitude below half its target sets the magnitude-half error flag.
// - detected error forces commutation outputs low and incremental outputs high.
// - per-mechanism safe-state enables, all off by default; cordic overflow and double error always force the safe state.
// - every response frame carries error and warning flags from diagnostics.
// - broken-chain threshold equals field times 256; zero switches it off.
// - broken-chain check idle by default, active only with nonzero threshold.
// - settings protection applies while the corrected enable bit is one.
// - corrected enable bit is shown as protection status.
// - settings bit errors appear in bits 2 and 3 of the flags.
// - single-bit settings errors are corrected at once.
// - double error raises frame error, single error raises frame warning.
// - settings error and warning flags are sticky.
// - protection register holds checksum in bits 6:0, enable in bit 7.
// - any diagnostic error switches the pulse-width output to error frame.
`timescale 1ns/1ps
`include "psd_cfg.svh"

module psd_diag (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  agc_value_i,
	input  wire logic        agc_at_limit_i,
	input  wire logic [13:0] vector_magnitude_i,
	input  wire logic        offset_fault_i,
	input  wire logic        cordic_overflow_i,
	input  wire logic [11:0] chain_deviation_i,
	input  wire logic [7:0]  raw_settings_i,
	input  wire logic [7:0]  protection_reg_i,
	input  wire logic        flag_read_i,
	input  wire logic [2:0]  commutation_i,
	input  wire logic [2:0]  incremental_i,
	output logic      [7:0]  agc_value_o,
	output logic      [7:0]  error_flag_register_o,
	output logic             frame_error_o,
	output logic             frame_warning_o,
	output logic      [2:0]  commutation_o,
	output logic      [2:0]  incremental_o,
	output logic             pwm_error_frame_o,
	output logic      [7:0]  corrected_settings_o,
	output logic             ecc_status_en_o,
	output logic      [7:0]  ecc_key_o
);

	// syndrome: xor of the positions of all set bits
	function automatic logic [3:0] psd_syndrome(input psd_pkg::psd_codeword_t cw);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 0; i < 13; i++) begin
			if (cw[i]) begin
				s = s ^ 4'(i + 1);
			end
		end
		return s;
	endfunction

	// data bits go to positions that are not powers of two
	function automatic psd_pkg::psd_codeword_t psd_place(input psd_pkg::psd_prot_data_t d);
		psd_pkg::psd_codeword_t cw;
		int                     j;
		cw = 13'h0000;
		j = 0;
		for (int i = 0; i < 13; i++) begin
			if (((i + 1) & i) != 0) begin
				cw[i] = d[j];
				j = j + 1;
			end
		end
		return cw;
	endfunction

	function automatic psd_pkg::psd_prot_data_t psd_extract(input psd_pkg::psd_codeword_t cw);
		psd_pkg::psd_prot_data_t d;
		int                      j;
		d = 9'h000;
		j = 0;
		for (int i = 0; i < 13; i++) begin
			if (((i + 1) & i) != 0) begin
				d[j] = cw[i];
				j = j + 1;
			end
		end
		return d;
	endfunction

	function automatic psd_pkg::psd_check_t psd_encode(input psd_pkg::psd_prot_data_t d);
		logic [3:0] p;
		p = psd_syndrome(psd_place(d));
		return {^d ^ ^p, p};
	endfunction

	psd_pkg::psd_prot_data_t raw_word;
	psd_pkg::psd_codeword_t  rx_cw;
	psd_pkg::psd_codeword_t  fix_cw;
	psd_pkg::psd_prot_data_t fixed_word;
	logic [3:0]              syn;
	logic                    overall;
	logic                    prot_en;
	logic                    ecc_sgl;
	logic                    ecc_dbl;
	logic [7:0]              use_settings;
	logic [11:0]             brk_limit;
	logic                    brk_fault;
	logic                    half_fault;
	logic                    force_safe;
	psd_pkg::psd_flags_t     cause;
	psd_pkg::psd_flags_t     flags;
	psd_pkg::psd_flags_t     next_flags;
	logic                    next_frame_error;
	logic                    next_frame_warning;
	logic [2:0]              next_commutation;
	logic [2:0]              next_incremental;
	logic                    next_pwm_error_frame;
	logic [7:0]              next_ecc_key;

	// settings decode and single-bit correction
	always_comb begin
		raw_word = {protection_reg_i[`PSD_PROT_EN_BIT], raw_settings_i};
		rx_cw = psd_place(raw_word);
		rx_cw[0] = protection_reg_i[0];
		rx_cw[1] = protection_reg_i[1];
		rx_cw[3] = protection_reg_i[2];
		rx_cw[7] = protection_reg_i[3];
		syn = psd_syndrome(rx_cw);
		overall = ^raw_word ^ ^protection_reg_i[4:0];
		fix_cw = rx_cw;
		if (overall && syn != 4'h0 && syn <= 4'hD) begin
			fix_cw[syn - 4'h1] = ~rx_cw[syn - 4'h1];
		end
		fixed_word = psd_extract(fix_cw);
		prot_en = fixed_word[8];
		ecc_sgl = prot_en && overall;
		ecc_dbl = prot_en && !overall && syn != 4'h0;
		use_settings = prot_en ? fixed_word[7:0] : raw_settings_i;
	end

	// fault detection
	always_comb begin
		brk_limit = 12'(use_settings[7:`PSD_SET_THR_LSB]) << `PSD_THR_SHIFT;
		brk_fault = (use_settings[7:`PSD_SET_THR_LSB] != 4'h0)
			&& (chain_deviation_i > brk_limit);
		half_fault = vector_magnitude_i < (`PSD_MAG_TARGET >> 1);
		cause = `PSD_FL_RESET;
		cause[`PSD_FL_GAIN] = agc_at_limit_i;
		cause[`PSD_FL_HALF] = half_fault;
		cause[`PSD_FL_ECC_SGL] = ecc_sgl;
		cause[`PSD_FL_ECC_DBL] = ecc_dbl;
		cause[`PSD_FL_BROKEN] = brk_fault;
		cause[`PSD_FL_OFFSET] = offset_fault_i;
		cause[`PSD_FL_CORDIC] = cordic_overflow_i;
		force_safe = (offset_fault_i && use_settings[`PSD_SET_OFFSET_EN])
			|| (half_fault && use_settings[`PSD_SET_HALF_EN])
			|| (agc_at_limit_i && use_settings[`PSD_SET_GAIN_EN])
			|| (brk_fault && use_settings[`PSD_SET_BROKEN_EN])
			|| cordic_overflow_i || ecc_dbl;
		next_commutation = force_safe ? `PSD_COMM_SAFE : commutation_i;
		next_incremental = force_safe ? `PSD_INCR_SAFE : incremental_i;
		next_pwm_error_frame = |cause;
		next_ecc_key = {3'h0, psd_encode(raw_word)};
	end

	// sticky flags: set wins over the read clear
	always_comb begin
		next_flags = (flag_read_i ? `PSD_FL_RESET : flags) | cause;
		next_frame_error = next_flags[`PSD_FL_HALF] || next_flags[`PSD_FL_ECC_DBL]
			|| next_flags[`PSD_FL_BROKEN] || next_flags[`PSD_FL_OFFSET]
			|| next_flags[`PSD_FL_CORDIC];
		next_frame_warning = next_flags[`PSD_FL_GAIN] || next_flags[`PSD_FL_ECC_SGL];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags <= `PSD_FL_RESET;
			frame_error_o <= 1'b0;
			frame_warning_o <= 1'b0;
			agc_value_o <= 8'h00;
			commutation_o <= `PSD_OUT_RESET;
			incremental_o <= `PSD_OUT_RESET;
			pwm_error_frame_o <= 1'b0;
			corrected_settings_o <= `PSD_SET_RESET;
			ecc_status_en_o <= 1'b0;
			ecc_key_o <= 8'h00;
		end else begin
			flags <= next_flags;
			frame_error_o <= next_frame_error;
			frame_warning_o <= next_frame_warning;
			agc_value_o <= agc_value_i;
			commutation_o <= next_commutation;
			incremental_o <= next_incremental;
			pwm_error_frame_o <= next_pwm_error_frame;
			corrected_settings_o <= use_settings;
			ecc_status_en_o <= prot_en;
			ecc_key_o <= next_ecc_key;
		end
	end

	assign error_flag_register_o = flags;

	property p_agc_visible;
		@(posedge clk_i) disable iff (!rst_n_i)
		1'b1 |=> agc_value_o == $past(agc_value_i);
	endproperty
	a_agc_visible: assert property (p_agc_visible) else $error("gain value not shown");

	property p_gain_warn;
		@(posedge clk_i) disable iff (!rst_n_i)
		agc_at_limit_i |=> error_flag_register_o[`PSD_FL_GAIN] && frame_warning_o;
	endproperty
	a_gain_warn: assert property (p_gain_warn) else $error("gain warning missing");

	property p_half_flag;
		@(posedge clk_i) disable iff (!rst_n_i)
		vector_magnitude_i < 14'h0800 |=> error_flag_register_o[`PSD_FL_HALF] && frame_error_o;
	endproperty
	a_half_flag: assert property (p_half_flag) else $error("half magnitude flag missing");

	property p_safe_state;
		@(posedge clk_i) disable iff (!rst_n_i)
		force_safe |=> commutation_o == 3'h0 && incremental_o == 3'h7;
	endproperty
	a_safe_state: assert property (p_safe_state) else $error("safe state not forced");

	property p_pass_through;
		@(posedge clk_i) disable iff (!rst_n_i)
		(use_settings[3:0] == 4'h0 && !cordic_overflow_i && !ecc_dbl)
			|=> commutation_o == $past(commutation_i) && incremental_o == $past(incremental_i);
	endproperty
	a_pass_through: assert property (p_pass_through) else $error("outputs forced while disabled");

	property p_brk_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		use_settings[7:4] == 4'h0 |-> !brk_fault;
	endproperty
	a_brk_off: assert property (p_brk_off) else $error("broken chain check active at zero");

	property p_brk_limit;
		@(posedge clk_i) disable iff (!rst_n_i)
		(use_settings[7:4] == 4'h4 && chain_deviation_i > 12'h400)
			|=> error_flag_register_o[`PSD_FL_BROKEN];
	endproperty
	a_brk_limit: assert property (p_brk_limit) else $error("broken chain threshold wrong");

	property p_ecc_gated;
		@(posedge clk_i) disable iff (!rst_n_i)
		!prot_en |-> !ecc_sgl && !ecc_dbl && use_settings == raw_settings_i;
	endproperty
	a_ecc_gated: assert property (p_ecc_gated) else $error("protection acts while off");

	property p_ecc_report;
		@(posedge clk_i) disable iff (!rst_n_i)
		ecc_dbl |=> error_flag_register_o[`PSD_FL_ECC_DBL] && frame_error_o;
	endproperty
	a_ecc_report: assert property (p_ecc_report) else $error("double error not reported");

	property p_sticky;
		@(posedge clk_i) disable iff (!rst_n_i)
		(error_flag_register_o[`PSD_FL_ECC_SGL] && !flag_read_i)
			|=> error_flag_register_o[`PSD_FL_ECC_SGL] [*1];
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky flag lost");

	property p_read_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(flag_read_i && cause == 8'h00) |=> error_flag_register_o == 8'h00 && !frame_error_o;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

	// a cause present in the read cycle keeps its bit
	property p_read_persist;
		@(posedge clk_i) disable iff (!rst_n_i)
		flag_read_i |=> error_flag_register_o == $past(cause);
	endproperty
	a_read_persist: assert property (p_read_persist) else $error("persisting fault lost on read");

	c_single_fix: cover property (@(posedge clk_i) disable iff (!rst_n_i) ecc_sgl ##1 flag_read_i);
	c_safe_force: cover property (@(posedge clk_i) disable iff (!rst_n_i) force_safe && brk_fault);
	c_double: cover property (@(posedge clk_i) disable iff (!rst_n_i) ecc_dbl);

endmodule

// ==== test/psd_host.sv ====
// Purpose: host model for settings, protection and flag reads
// Assumes: one clock, commands from the bench
// Notes: flip_i injects settings faults on command
`timescale 1ns/1ps
module psd_host (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] set_i,
	input  wire logic       en_i,
	input  wire logic       load_i,
	input  wire logic       read_i,
	input  wire logic [8:0] flip_i,
	input  wire logic [7:0] key_i,
	output logic      [7:0] set_o,
	output logic      [7:0] prot_o,
	output logic            read_o
);
	logic [7:0] s;
	logic [7:0] p;
	logic [1:0] n;
	assign set_o  = s ^ flip_i[7:0];
	assign prot_o = {p[7] ^ flip_i[8], p[6:0]};
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s      <= 8'h00;
			p      <= 8'h00;
			n      <= 2'h0;
			read_o <= 1'h0;
		end else begin
			read_o <= read_i;
			if (load_i) begin
				s <= set_i;
				p <= {en_i, 7'h00};
				n <= 2'h1;
			end else if (n == 2'h3) begin
				// key taken once it reflects the enable
				p[6:0] <= key_i[6:0];
				n      <= 2'h0;
			end else if (n != 2'h0) begin
				n <= n + 2'h1;
			end
		end
	end
endmodule

// ==== test/psd_diag_test.sv ====
// Purpose: self-checking bench of the diagnostics block
// Assumes: 50 MHz clock, host model on the settings side
// Notes: lfsr stimulus with boundary values
`timescale 1ns/1ps
module psd_diag_test;
	logic        clk_i = 1'h0, rst_n_i = 1'h0, lim = 1'h0, off = 1'h0, cor = 1'h0;
	logic        he = 1'h0, hl = 1'h0, hr = 1'h0, fe, fw, pwm, een, rd;
	logic [7:0]  agc = 8'h00, hs = 8'h00, agc_o, fl, cs, key, raw, prot;
	logic [13:0] vector_magnitude = 14'h1000;
	logic [11:0] dev = 12'h000;
	logic [2:0]  cm = 3'h0, ic = 3'h0, cm_o, ic_o;
	logic [8:0]  hf = 9'h000;
	logic [31:0] rnd = 32'h77D5304F;
	int          error_cnt = 0, samples_checked = 0;
	always #10 clk_i = ~clk_i;
	psd_diag psd_diag_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .agc_value_i(agc),
		.agc_at_limit_i(lim), .vector_magnitude_i(vector_magnitude), .offset_fault_i(off),
		.cordic_overflow_i(cor), .chain_deviation_i(dev), .raw_settings_i(raw),
		.protection_reg_i(prot), .flag_read_i(rd), .commutation_i(cm), .incremental_i(ic),
		.agc_value_o(agc_o), .error_flag_register_o(fl), .frame_error_o(fe),
		.frame_warning_o(fw), .commutation_o(cm_o), .incremental_o(ic_o),
		.pwm_error_frame_o(pwm), .corrected_settings_o(cs), .ecc_status_en_o(een),
		.ecc_key_o(key));
	psd_host psd_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .set_i(hs), .en_i(he),
		.load_i(hl), .read_i(hr), .flip_i(hf), .key_i(key), .set_o(raw), .prot_o(prot),
		.read_o(rd));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [7:0] ekey(input logic [8:0] d);
		logic [3:0] p;
		p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6] ^ d[8];
		p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
		p[2] = d[1] ^ d[2] ^ d[3] ^ d[7] ^ d[8];
		p[3] = ^d[8:4];
		return {3'h0, ^{d, p}, p};
	endfunction
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic clr;
		hr <= 1'h1;
		tk(1);
		hr <= 1'h0;
		tk(2);
	endtask
	task automatic load(input logic [7:0] s, input logic en);
		hs <= s;
		he <= en;
		hl <= 1'h1;
		tk(1);
		hl <= 1'h0;
		tk(5);
		clr();
	endtask
	task automatic fault(input logic [7:0] s, input logic [3:0] c, input logic lo);
		logic [7:0] ef;
		logic       sf;
		load(s, 1'h0);
		rnd = lfsr(rnd);
		lim <= c[0];
		off <= c[1];
		cor <= c[2];
		dev <= {s[7:4], 8'h00} + {11'h000, c[3]};
		vector_magnitude <= lo ? 14'h07FF : 14'h0800;
		agc <= rnd[7:0];
		cm  <= rnd[10:8];
		ic  <= rnd[13:11];
		tk(1);
		ef = {1'h0, c[2], c[1], c[3] && s[7:4] != 4'h0, 2'h0, lo, c[0]};
		sf = c[2] | (c[0] & s[2]) | (lo & s[1]) | (c[1] & s[0]) | (ef[4] & s[3]);
		chk(fl, ef);
		chk(fe, ef[1] | ef[4] | ef[5] | ef[6]);
		chk(fw, ef[0]);
		chk(cm_o, sf ? 3'h0 : cm);
		chk(ic_o, sf ? 3'h7 : ic);
		chk(pwm, |ef);
		chk(agc_o, agc);
		chk(key, ekey({1'h0, s}));
		{lim, off, cor, dev, vector_magnitude} <= {15'h0000, 14'h1000};
		tk(2);
		chk(fl, ef);
		chk(pwm, 8'h00);
		clr();
		chk(fl, 8'h00);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		logic [7:0] s;
		tk(16);
		chk(fl, 8'h00);
		chk(cs, 8'h00);
		rst_n_i <= 1'h1;
		tk(1);
		fault(8'h4F, 4'h8, 1'h0);
		fault(8'h0F, 4'h8, 1'h0);
		fault(8'h00, 4'hF, 1'h1);
		repeat (40) begin
			rnd = lfsr(rnd);
			fault(rnd[7:0], rnd[11:8], rnd[12]);
		end
		rnd = lfsr(rnd);
		s = rnd[7:0];
		load(s, 1'h1);
		chk(een, 8'h01);
		chk(cs, s);
		chk(key, ekey({1'h1, s}));
		chk(fl, 8'h00);
		for (int i = 0; i < 3; i++) begin
			hf <= i == 0 ? 9'h008 : (i == 1 ? 9'h003 : 9'h100);
			tk(2);
			chk(fl, i == 1 ? 8'h08 : 8'h04);
			chk(fe, i == 1);
			chk(fw, i != 1);
			if (i != 1) begin
				chk(cs, s);
				chk(een, 8'h01);
			end else begin
				chk({cm_o, ic_o}, 8'h07);
			end
			hf <= 9'h000;
			tk(2);
			chk(fl, i == 1 ? 8'h08 : 8'h04);
			clr();
			chk(fl, 8'h00);
		end
		load(s, 1'h0);
		hf <= 9'h001;
		tk(2);
		chk(cs, s ^ 8'h01);
		chk(fl, 8'h00);
		// read while gain fault persists, half fault already gone
		lim <= 1'h1;
		vector_magnitude <= 14'h07FF;
		tk(1);
		vector_magnitude <= 14'h1000;
		clr();
		chk(fl, 8'h01);
		chk(fw, 8'h01);
		chk(fe, 8'h00);
		report_and_stop();
	end
	initial begin
		#1000000;
		error_cnt++;
		report_and_stop();
	end
endmodule
